// >>> oled_reset_pkg.sv
package oled_reset_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_MUX      = 8'h04;
  localparam logic [7:0] OFS_START    = 8'h08;
  localparam logic [7:0] OFS_CONTRAST = 8'h0C;
  localparam logic [7:0] OFS_COLUMN   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_CMD      = 8'h18;

  // Reset values
  localparam logic [7:0] MUX_RST      = 8'hA0;
  localparam logic [7:0] START_RST    = 8'h00;
  localparam logic [7:0] CONTRAST_RST = 8'h7F;
  localparam logic [7:0] COLUMN_RST   = 8'h00;

  // Command opcodes
  localparam logic [7:0] OP_DISP_OFF  = 8'hAE;
  localparam logic [7:0] OP_DISP_ON   = 8'hAF;
  localparam logic [7:0] OP_NORMAL    = 8'hA6;
  localparam logic [7:0] OP_INVERSE   = 8'hA7;
  localparam logic [7:0] OP_LUT_LIN   = 8'hB9;
  localparam logic [7:0] OP_LUT_CUST  = 8'hB8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Control word; bit 0 is display_on
  typedef struct packed {
    logic lut_custom;
    logic com_reverse;
    logic seg_remap;
    logic inverse;
    logic display_on;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = ctrl_s'(5'h00);

  // Decoded command strobes
  typedef struct packed {
    logic on;
    logic off;
    logic normal;
    logic invert;
    logic lut_lin;
    logic lut_cust;
  } cmd_s;

endpackage : oled_reset_pkg

// >>> serial_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module serial_shifter
  import oled_reset_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Serial input
  input  wire logic       select_n_i,
  input  wire logic       bit_valid_i,
  input  wire logic       bit_i,
  input  wire logic       dc_i,
  // Assembled byte
  output logic            byte_valid_o,
  output logic [7:0]      byte_o,
  output logic            byte_dc_o,
  output logic [2:0]      count_o
);

  logic [6:0] shift_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || select_n_i) begin
      shift_reg <= 7'h00;
      count_o   <= 3'h0;
    end else if (bit_valid_i) begin
      shift_reg <= {shift_reg[5:0], bit_i};
      count_o   <= count_o + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
      byte_dc_o    <= 1'b0;
    end else begin
      byte_valid_o <= !select_n_i && bit_valid_i && (count_o == 3'h7);
      if (!select_n_i && bit_valid_i && (count_o == 3'h7)) begin
        byte_o    <= {shift_reg, bit_i};
        byte_dc_o <= dc_i;
      end
    end
  end

endmodule : serial_shifter
`default_nettype wire

// >>> cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module cmd_decode
  import oled_reset_pkg::*;
(
  // Command byte
  input  wire logic       valid_i,
  input  wire logic [7:0] opcode_i,
  // Decoded strobes
  output cmd_s            cmd_o
);

  always_comb begin
    cmd_o          = cmd_s'(6'h00);
    cmd_o.off      = valid_i && (opcode_i == OP_DISP_OFF);
    cmd_o.on       = valid_i && (opcode_i == OP_DISP_ON);
    cmd_o.normal   = valid_i && (opcode_i == OP_NORMAL);
    cmd_o.invert   = valid_i && (opcode_i == OP_INVERSE);
    cmd_o.lut_lin  = valid_i && (opcode_i == OP_LUT_LIN);
    cmd_o.lut_cust = valid_i && (opcode_i == OP_LUT_CUST);
  end

endmodule : cmd_decode
`default_nettype wire

// >>> oled_reset_defaults.sv
// Function
// - Reset loads defaults, display switched off
// - Multiplex ratio defaults to 160 rows
// - Normal segment and row mapping
// - Serial shift register cleared on reset
// - Start line points at row 0
// - Column address counter cleared to 0
// - Common outputs scan in normal direction
// - Contrast register loads 7Fh
// - Default linear grayscale table selected
// - Normal, non-inverted display selected
`timescale 1ns/100ps
`default_nettype none
module oled_reset_defaults
  import oled_reset_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Serial command and data input
  input  wire logic        ser_select_n_i,
  input  wire logic        ser_bit_valid_i,
  input  wire logic        ser_bit_i,
  input  wire logic        ser_dc_i,
  // Display control state
  output ctrl_s            ctrl_o,
  output logic [7:0]       mux_ratio_o,
  output logic [7:0]       start_line_o,
  output logic [7:0]       contrast_o,
  output logic [7:0]       column_addr_o
);

  ctrl_s       ctrl_reg;
  logic [7:0]  mux_reg;
  logic [7:0]  start_reg;
  logic [7:0]  contrast_reg;
  logic [7:0]  column_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic        wr_lane0;
  logic        byte_valid;
  logic [7:0]  ser_byte;
  logic        ser_dc;
  logic [2:0]  ser_count;
  logic        ser_cmd_valid;
  logic        ser_data_valid;
  logic        bus_cmd_valid;
  cmd_s        ser_cmd;
  cmd_s        bus_cmd;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFS_CTRL) || (addr == OFS_MUX) || (addr == OFS_START)
             || (addr == OFS_CONTRAST) || (addr == OFS_COLUMN)
             || (addr == OFS_STATUS) || (addr == OFS_CMD);
  endfunction : is_mapped

  // Serial front end
  serial_shifter u_shifter (
    .clock_i      (clock_i),
    .reset_n_i    (reset_n_i),
    .select_n_i   (ser_select_n_i),
    .bit_valid_i  (ser_bit_valid_i),
    .bit_i        (ser_bit_i),
    .dc_i         (ser_dc_i),
    .byte_valid_o (byte_valid),
    .byte_o       (ser_byte),
    .byte_dc_o    (ser_dc),
    .count_o      (ser_count)
  );

  assign ser_cmd_valid  = byte_valid && !ser_dc;
  assign ser_data_valid = byte_valid && ser_dc;
  // A pending response blocks the next write, so one write is outstanding
  assign do_write       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane0       = do_write && wstrb_reg[0] && is_mapped(waddr_reg);
  assign bus_cmd_valid  = wr_lane0 && (waddr_reg == OFS_CMD);

  // Two decoders so a bus and a serial command in one cycle both apply; in a conflict on, invert and custom table win
  cmd_decode u_ser_dec (
    .valid_i  (ser_cmd_valid),
    .opcode_i (ser_byte),
    .cmd_o    (ser_cmd)
  );

  // Bus command taken from the low data byte only
  cmd_decode u_bus_dec (
    .valid_i  (bus_cmd_valid),
    .opcode_i (wdata_reg[7:0]),
    .cmd_o    (bus_cmd)
  );

  // Bus handshakes; nothing is accepted while reset is held
  assign s_axi_awready = reset_n_i && !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = reset_n_i && !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = reset_n_i && !s_axi_rvalid;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      aw_held_reg <= 1'b0;
      waddr_reg   <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      waddr_reg   <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; status shows the serial bit count in flight
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL:     s_axi_rdata <= {27'h0, ctrl_reg};
        OFS_MUX:      s_axi_rdata <= {24'h000000, mux_reg};
        OFS_START:    s_axi_rdata <= {24'h000000, start_reg};
        OFS_CONTRAST: s_axi_rdata <= {24'h000000, contrast_reg};
        OFS_COLUMN:   s_axi_rdata <= {24'h000000, column_reg};
        OFS_STATUS:   s_axi_rdata <= {29'h0, ser_count};
        default:      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control word: bus write first, then serial and bus commands applied together
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (wr_lane0 && (waddr_reg == OFS_CTRL)) begin
        ctrl_reg <= ctrl_s'(wdata_reg[4:0]);
      end
      if (ser_cmd.off || bus_cmd.off) begin
        ctrl_reg.display_on <= 1'b0;
      end
      if (ser_cmd.on || bus_cmd.on) begin
        ctrl_reg.display_on <= 1'b1;
      end
      if (ser_cmd.normal || bus_cmd.normal) begin
        ctrl_reg.inverse <= 1'b0;
      end
      if (ser_cmd.invert || bus_cmd.invert) begin
        ctrl_reg.inverse <= 1'b1;
      end
      if (ser_cmd.lut_lin || bus_cmd.lut_lin) begin
        ctrl_reg.lut_custom <= 1'b0;
      end
      if (ser_cmd.lut_cust || bus_cmd.lut_cust) begin
        ctrl_reg.lut_custom <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mux_reg <= MUX_RST;
    end else if (wr_lane0 && (waddr_reg == OFS_MUX)) begin
      mux_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      start_reg <= START_RST;
    end else if (wr_lane0 && (waddr_reg == OFS_START)) begin
      start_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      contrast_reg <= CONTRAST_RST;
    end else if (wr_lane0 && (waddr_reg == OFS_CONTRAST)) begin
      contrast_reg <= wdata_reg[7:0];
    end
  end

  // Bus load wins over a serial data increment in the same cycle
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      column_reg <= COLUMN_RST;
    end else if (wr_lane0 && (waddr_reg == OFS_COLUMN)) begin
      column_reg <= wdata_reg[7:0];
    end else if (ser_data_valid) begin
      column_reg <= column_reg + 8'h01;
    end
  end

  assign ctrl_o        = ctrl_reg;
  assign mux_ratio_o   = mux_reg;
  assign start_line_o  = start_reg;
  assign contrast_o    = contrast_reg;
  assign column_addr_o = column_reg;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // Defaults as seen at the first edge after release; bus refused in reset; write response timing
  AST_DISPLAY_OFF: assert property ($rose(reset_n_i) |-> !ctrl_o.display_on)
    else $error("display not off after reset");
  AST_MUX_160: assert property ($rose(reset_n_i) |-> mux_ratio_o == 8'hA0)
    else $error("mux ratio not 160 after reset");
  AST_MAPPING: assert property ($rose(reset_n_i) |-> !ctrl_o.seg_remap)
    else $error("segment mapping not normal after reset");
  AST_SHIFT_CLEAR: assert property ($rose(reset_n_i) |-> ser_count == 3'h0 && !byte_valid)
    else $error("serial shift state not cleared");
  AST_START_ZERO: assert property ($rose(reset_n_i) |-> start_line_o == 8'h00)
    else $error("start line not zero after reset");
  AST_COLUMN_ZERO: assert property ($rose(reset_n_i) |-> column_addr_o == 8'h00)
    else $error("column counter not zero after reset");
  AST_COM_SCAN: assert property ($rose(reset_n_i) |-> !ctrl_o.com_reverse)
    else $error("common scan reversed after reset");
  AST_CONTRAST: assert property ($rose(reset_n_i) |-> contrast_o == 8'h7F)
    else $error("contrast not 7F after reset");
  AST_LUT_LINEAR: assert property ($rose(reset_n_i) |-> !ctrl_o.lut_custom)
    else $error("grayscale table not linear after reset");
  AST_NORMAL_MODE: assert property ($rose(reset_n_i) |-> !ctrl_o.inverse)
    else $error("display inverted after reset");
  AST_IGNORE_BUS: assert property (@(posedge clock_i) disable iff (1'b0) !reset_n_i
      |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus accepted during reset");
  AST_WRITE_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after handshake");

  // Handshakes and responses
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped before rready");
  AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response not one edge after handshake");
  AST_AW_GATE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  AST_AR_GATE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  AST_UNMAPPED_RD: assert property (s_axi_arvalid && s_axi_arready && !is_mapped(s_axi_araddr)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_BRESP_UNMAPPED: assert property (do_write && !is_mapped(waddr_reg)
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // Commands and counters
  AST_CMD_ON: assert property (ser_cmd.on || bus_cmd.on |=> ctrl_o.display_on)
    else $error("display on command not applied");
  AST_CMD_OFF: assert property ((ser_cmd.off || bus_cmd.off) && !(ser_cmd.on || bus_cmd.on)
      |=> !ctrl_o.display_on)
    else $error("display off command not applied");
  AST_NORMAL_CMD: assert property ((ser_cmd.normal || bus_cmd.normal)
      && !(ser_cmd.invert || bus_cmd.invert) |=> !ctrl_o.inverse)
    else $error("normal display command not applied");
  AST_LUT_CMD: assert property ((ser_cmd.lut_lin || bus_cmd.lut_lin)
      && !(ser_cmd.lut_cust || bus_cmd.lut_cust) |=> !ctrl_o.lut_custom)
    else $error("linear table command not applied");
  AST_SELECT_CLEAR: assert property (ser_select_n_i |=> ser_count == 3'h0)
    else $error("partial byte kept after deselect");
  AST_COLUMN_STEP: assert property (ser_data_valid && !(wr_lane0 && (waddr_reg == OFS_COLUMN))
      |=> column_addr_o == 8'($past(column_addr_o) + 8'h01))
    else $error("column counter did not step on data");
  AST_COLUMN_HOLD: assert property (!ser_data_valid && !(wr_lane0 && (waddr_reg == OFS_COLUMN))
      |=> $stable(column_addr_o))
    else $error("column counter moved without cause");

  // Registers hold without a write
  AST_MUX_HOLD: assert property (!(wr_lane0 && (waddr_reg == OFS_MUX)) |=> $stable(mux_ratio_o))
    else $error("mux ratio changed without a write");
  AST_START_HOLD: assert property (!(wr_lane0 && (waddr_reg == OFS_START)) |=> $stable(start_line_o))
    else $error("start line changed without a write");
  AST_CONTRAST_HOLD: assert property (!(wr_lane0 && (waddr_reg == OFS_CONTRAST)) |=> $stable(contrast_o))
    else $error("contrast changed without a write");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_SER_CMD: cover property (ser_cmd_valid);
  COV_COLUMN_STEP: cover property (ser_data_valid ##1 column_addr_o != 8'h00);
  COV_RELEASE: cover property ($rose(reset_n_i));

endmodule : oled_reset_defaults
`default_nettype wire

// >>> host_link.sv
`timescale 1ns/100ps
`default_nettype none
module host_link #(
  parameter int SUPPLY_GAP = 4
) (
  // Clock
  input  wire logic clock_i,
  // Serial lines toward the display
  output logic      select_n_o,
  output logic      bit_valid_o,
  output logic      bit_o,
  output logic      dc_o
);
  // Supply rails; the panel rail floats whenever it is off
  logic logic_rail_on;
  logic panel_rail_on;
  logic panel_rail_driven;

  initial begin
    logic_rail_on     = 1'b0;
    panel_rail_on     = 1'b0;
    panel_rail_driven = 1'b0;
    select_n_o  = 1'b1;
    bit_valid_o = 1'b0;
    bit_o       = 1'b0;
    dc_o        = 1'b0;
  end

  // Sends n bits MSB first; hold keeps the frame open for a partial byte
  task send(input logic [7:0] b, input logic dc, input int n, input logic hold);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      select_n_o  <= 1'b0;
      bit_valid_o <= 1'b1;
      bit_o       <= b[7-i];
      dc_o        <= dc;
    end
    @(posedge clock_i);
    bit_valid_o <= 1'b0;
    if (!hold) begin
      select_n_o <= 1'b1;
    end
    // Idle data lines toggle so a stale bit never looks valid
    bit_o <= ~bit_o;
    dc_o  <= ~dc_o;
  endtask : send

  // Logic rail first; panel rail after a settling gap
  task power_up;
    logic_rail_on <= 1'b1;
    repeat (SUPPLY_GAP) @(posedge clock_i);
    panel_rail_on     <= 1'b1;
    panel_rail_driven <= 1'b1;
  endtask : power_up

  // Panel rail first and left floating; logic rail only after the gap
  task power_down;
    panel_rail_on     <= 1'b0;
    panel_rail_driven <= 1'b0;
    repeat (SUPPLY_GAP) @(posedge clock_i);
    logic_rail_on <= 1'b0;
  endtask : power_down

  task close_frame;
    @(posedge clock_i);
    select_n_o <= 1'b1;
  endtask : close_frame
endmodule : host_link
`default_nettype wire

// >>> oled_driver_reset_defaults_test.sv
`timescale 1ns/100ps
`default_nettype none
module oled_driver_reset_defaults_test
  import oled_reset_pkg::*;
;
  logic        clock_i, reset_n_i, ser_select_n_i, ser_bit_valid_i, ser_bit_i, ser_dc_i;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mux_ratio_o, start_line_o;
  logic [7:0]  contrast_o, column_addr_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  ctrl_s       ctrl_o;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;

  oled_reset_defaults dut (.clock_i, .reset_n_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ser_select_n_i, .ser_bit_valid_i, .ser_bit_i, .ser_dc_i, .ctrl_o, .mux_ratio_o,
    .start_line_o, .contrast_o, .column_addr_o);

  host_link link (.clock_i, .select_n_o(ser_select_n_i), .bit_valid_o(ser_bit_valid_i),
    .bit_o(ser_bit_i), .dc_o(ser_dc_i));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task final_report;
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Whole run needs under two hundred cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] act, input logic [31:0] exp);
    tests_run++;
    if (act !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %08h expected %08h", $time, act, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  // Ready sampled at the low phase, stable up to the taking edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, t;
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clock_i);
      da = da | (s_axi_awvalid & s_axi_awready);
      dw = dw | (s_axi_wvalid & s_axi_wready);
      @(posedge clock_i);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end while (!(da && dw));
    do begin
      @(negedge clock_i);
      t   = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clock_i);
    end while (!t);
    s_axi_bready <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic t;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clock_i);
      t = s_axi_arready;
      @(posedge clock_i);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clock_i);
      t   = s_axi_rvalid;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clock_i);
    end while (!t);
    s_axi_rready <= 1'b0;
    @(posedge clock_i);
    chk(rd, e);
    chk(32'(rsp), 32'(r));
  endtask : rchk

  task s_defaults;
    chk(32'(ctrl_o.display_on), 32'h0);
    chk(32'(ctrl_o.seg_remap), 32'h0);
    chk(32'(ctrl_o.com_reverse), 32'h0);
    chk(32'(ctrl_o.lut_custom), 32'h0);
    chk(32'(ctrl_o.inverse), 32'h0);
    chk(32'(mux_ratio_o), 32'h0000_00A0);
    chk(32'(start_line_o), 32'h0);
    chk(32'(column_addr_o), 32'h0);
    chk(32'(contrast_o), 32'h0000_007F);
    rchk(OFS_MUX, 32'h0000_00A0, RESP_OKAY);
    rchk(OFS_STATUS, 32'h0, RESP_OKAY);
  endtask : s_defaults

  task s_commands;
    logic [7:0] op [6] = '{8'hAF, 8'hA7, 8'hB8, 8'hB9, 8'hA6, 8'hAE};
    logic [4:0] ex [6] = '{5'h01, 5'h03, 5'h13, 5'h03, 5'h01, 5'h00};
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CMD, {24'h0, op[i]});
      chk(32'(ctrl_o), 32'(ex[i]));
    end
    // Column counter wraps at the top
    wr(OFS_COLUMN, 32'h0000_00FF);
    link.send(8'h5A, 1'b1, 8, 1'b0);
    cyc(3);
    chk(32'(column_addr_o), 32'h0);
  endtask : s_commands

  task s_recover;
    wr(OFS_CTRL, 32'h0000_001E);
    wr(OFS_MUX, 32'h0000_003F);
    wr(OFS_START, 32'h0000_0011);
    wr(OFS_CONTRAST, 32'h0000_0022);
    link.send(8'hAF, 1'b0, 8, 1'b0);
    link.send(8'h00, 1'b0, 5, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0005, RESP_OKAY);
    chk(32'(ctrl_o), 32'h0000_001F);
    rchk(OFS_MUX, 32'h0000_003F, RESP_OKAY);
    rchk(OFS_START, 32'h0000_0011, RESP_OKAY);
    rchk(OFS_CONTRAST, 32'h0000_0022, RESP_OKAY);
    reset_n_i <= 1'b0;
    cyc(2);
    reset_n_i <= 1'b1;
    cyc(1);
    s_defaults();
    link.close_frame();
  endtask : s_recover

  task s_held;
    reset_n_i <= 1'b0;
    @(negedge clock_i);
    chk(32'(s_axi_awready), 32'h0);
    chk(32'(s_axi_wready), 32'h0);
    chk(32'(s_axi_arready), 32'h0);
    // Release right after the last bit, so a byte kept in reset would apply
    link.send(8'hAF, 1'b0, 8, 1'b0);
    reset_n_i <= 1'b1;
    cyc(2);
    chk(32'(ctrl_o.display_on), 32'h0);
    rchk(OFS_STATUS, 32'h0, RESP_OKAY);
  endtask : s_held

  initial begin
    reset_n_i     = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    link.power_up();
    cyc(10);
    reset_n_i <= 1'b1;
    cyc(1);
    s_defaults();
    s_commands();
    s_recover();
    s_held();
    wr(8'h1C, 32'h0000_00FF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rchk(8'h1C, 32'h0, RESP_SLVERR);
    link.power_down();
    final_report();
  end
endmodule : oled_driver_reset_defaults_test
`default_nettype wire
